// ===== design/irq_dispatch_power_modes.sv
// Interrupt dispatch, priority tracking and idle / power-down control
// Function
// R01 - Capture request flags at S5P2 each machine cycle, evaluate them next cycle.
// R02 - A set, unblocked captured flag forces a long call to its vector.
// R03 - No call while an equal or higher level routine is in progress.
// R04 - No call unless this is the last cycle of the instruction.
// R05 - No call during interrupt return or enable/priority register access.
// R06 - Denied requests are forgotten; each poll is fresh.
// R07 - Call pushes program counter, loads vector, leaves status word alone.
// R08 - Fixed vectors 0003h to 004Bh per source.
// R09 - Interrupt return clears the active level marker and resumes code.
// R10 - Plain return keeps the marker set, blocking that level and below.
// R11 - Main priority: timer2 b5, serial1 b4, timer1 b3, ext1 b2, timer0 b1, ext0 b0.
// R12 - Extra priority: serial2 at bit 4, two-wire at bit 1.
// R13 - Idle bit halts the processor; state kept, peripherals keep running.
// R14 - Any enabled interrupt clears idle and is serviced; here idle clears only on a taken call, not for a level-blocked request.
// R15 - External reset must be held at least two machine cycles to leave idle.
// R16 - After internal reset the processor restarts after 3 machine cycles.
// R17 - Power-down bit stops the oscillator; only reset ends it.
// R18 - In power-down low-voltage detect stays on; PWM and two-wire disabled.
// R19 - Power control register at 87 resets to 00 with its eight fields.
// R20 - High level routines are never preempted; low ones yield to high.
// R21 - Same level requests resolve in fixed polling order.
// R22 - Cleared global enable stops every interrupt acknowledge.
// R23 - Converter completion takes over the external 1 request when enabled.
// R24 - Any reset clears idle, power-down and level markers, restarts oscillator.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "irq_dispatch_defs.svh"

module irq_dispatch_power_modes
  import irq_dispatch_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sampleStrobe,
  input wire logic pollStrobe,
  input wire core_status_t coreStatus,
  input wire logic retiStrobe,
  input wire logic [`NUM_SRC-1:0] irqFlags,
  input wire logic adcDone,
  input wire logic internalReset,
  output call_t forcedCall,
  output logic cpuHalt,
  output logic oscStop,
  output logic unitDisable,
  output logic lowVoltDetectOn,
  output logic restartHold,
  output logic serial1DoubleRate,
  output logic serial2DoubleRate,
  output logic lowVoltResetDisable,
  output logic converterIrqEnable,
  output logic serial2RxClockSel,
  output logic serial2TxClockSel
);

  // ***************************************************
  // Functions
  // ***************************************************

  function automatic reg_sel_t decodeAddr(input logic [`ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == {2'b00, `IDX_POWER, 2'b00}) begin
      s = SEL_POWER;
    end else if (a == {2'b00, `IDX_PRIO_MAIN, 2'b00}) begin
      s = SEL_PRIO_MAIN;
    end else if (a == {2'b00, `IDX_PRIO_EXTRA, 2'b00}) begin
      s = SEL_PRIO_EXTRA;
    end else if (a == {2'b00, `IDX_EN_MAIN, 2'b00}) begin
      s = SEL_EN_MAIN;
    end else if (a == {2'b00, `IDX_EN_EXTRA, 2'b00}) begin
      s = SEL_EN_EXTRA;
    end else if (a == {2'b00, `IDX_STATUS, 2'b00}) begin
      s = SEL_STATUS;
    end
    return s;
  endfunction : decodeAddr

  // Lowest set bit wins, which is the polling order
  function automatic logic [`NUM_SRC-1:0] firstOne(input logic [`NUM_SRC-1:0] v);
    return v & `NUM_SRC'(~v + `NUM_SRC'(1));
  endfunction : firstOne

  function automatic logic [15:0] vectorOf(input logic [`NUM_SRC-1:0] oneHot);
    logic [15:0] vec;
    vec = 16'h0000;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (oneHot[i]) begin
        case (src_t'(i))
          SRC_EXT0: vec = `VEC_EXT0;
          SRC_SER2: vec = `VEC_SER2;
          SRC_T0: vec = `VEC_T0;
          SRC_TWOWIRE: vec = `VEC_TWOWIRE;
          SRC_EXT1: vec = `VEC_EXT1;
          SRC_T1: vec = `VEC_T1;
          SRC_SER1: vec = `VEC_SER1;
          SRC_T2: vec = `VEC_T2;
          default: vec = 16'h0000;
        endcase
      end
    end
    return vec;
  endfunction : vectorOf

  // ***************************************************
  // Registers
  // ***************************************************

  logic [7:0] powerControl;
  logic [7:0] priorityMain;
  logic [7:0] priorityExtra;
  logic [7:0] enableMain;
  logic [7:0] enableExtra;
  logic inProgLow;
  logic inProgHigh;
  logic [1:0] restartCount;
  logic [`NUM_SRC-1:0] sampled;

  reg_sel_t busSel;
  logic busWrite;
  logic [7:0] next_power;
  logic [7:0] readValue;

  assign busSel = decodeAddr(paddr);
  assign busWrite = psel & penable & pready & pwrite;

  // ***************************************************
  // Register bus slave
  // ***************************************************

  // One wait-free access phase: pready rises in the cycle after setup
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      // Error pulses with ready only, so a stale error never qualifies a later cycle
      pslverr <= psel & ~penable & (busSel == SEL_NONE);
      if (psel & ~penable) begin
        prdata <= {24'h00_0000, readValue};
      end
    end
  end

  always_comb begin
    readValue = 8'h00;
    case (busSel)
      SEL_POWER: readValue = powerControl;
      SEL_PRIO_MAIN: readValue = priorityMain;
      SEL_PRIO_EXTRA: readValue = priorityExtra;
      SEL_EN_MAIN: readValue = enableMain;
      SEL_EN_EXTRA: readValue = enableExtra;
      SEL_STATUS: begin
        readValue[`ST_PROG_LO] = inProgLow;
        readValue[`ST_PROG_HI] = inProgHigh;
        readValue[`ST_OSC_STOP] = oscStop;
      end
      default: readValue = 8'h00;
    endcase
  end

  // Priority and enable registers; reserved bits held at zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      priorityMain <= `RST_PRIO;
      priorityExtra <= `RST_PRIO;
      enableMain <= `RST_EN;
      enableExtra <= `RST_EN;
    end else if (internalReset) begin
      priorityMain <= `RST_PRIO;
      priorityExtra <= `RST_PRIO;
      enableMain <= `RST_EN;
      enableExtra <= `RST_EN;
    end else if (busWrite) begin
      case (busSel)
        SEL_PRIO_MAIN: priorityMain <= pwdata[7:0] & `MASK_PRIO_MAIN; // R11
        SEL_PRIO_EXTRA: priorityExtra <= pwdata[7:0] & `MASK_EXTRA; // R12
        SEL_EN_MAIN: enableMain <= pwdata[7:0] & `MASK_EN_MAIN;
        SEL_EN_EXTRA: enableExtra <= pwdata[7:0] & `MASK_EXTRA;
        default: ;
      endcase
    end
  end

  // ***************************************************
  // Request sampling
  // ***************************************************

  logic [`NUM_SRC-1:0] reqLine;
  logic [`NUM_SRC-1:0] enableVec;
  logic [`NUM_SRC-1:0] levelVec;

  always_comb begin
    reqLine = irqFlags;
    if (powerControl[`PC_ADC]) begin
      reqLine[SRC_EXT1] = adcDone; // R23
    end
  end

  assign enableVec = {enableMain[`B_T2], enableMain[`B_SER1], enableMain[`B_T1],
                      enableMain[`B_EXT1], enableExtra[`B_TWOWIRE], enableMain[`B_T0],
                      enableExtra[`B_SER2], enableMain[`B_EXT0]};
  assign levelVec = {priorityMain[`B_T2], priorityMain[`B_SER1], priorityMain[`B_T1],
                     priorityMain[`B_EXT1], priorityExtra[`B_TWOWIRE], priorityMain[`B_T0],
                     priorityExtra[`B_SER2], priorityMain[`B_EXT0]};

  // Samples are overwritten every machine cycle, so a denied request
  // leaves no trace once its flag drops
  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g++) begin : gSample
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          sampled[g] <= 1'b0;
        end else if (internalReset) begin
          sampled[g] <= 1'b0;
        end else if (sampleStrobe) begin // R01 R06
          sampled[g] <= reqLine[g] & enableVec[g] & enableMain[`B_GLOBAL]; // R22
        end
      end
    end
  endgenerate

  // ***************************************************
  // Polling and arbitration
  // ***************************************************

  logic [`NUM_SRC-1:0] hiReq;
  logic [`NUM_SRC-1:0] loReq;
  logic [`NUM_SRC-1:0] pick;
  logic pickHigh;
  logic grant;
  logic instrOk;
  logic takeCall;

  assign hiReq = sampled & levelVec;
  assign loReq = sampled & ~levelVec;

  always_comb begin
    pick = '0;
    pickHigh = 1'b0;
    grant = 1'b0;
    if (hiReq != '0 && !inProgHigh) begin // R20 R03
      pick = firstOne(hiReq); // R21
      pickHigh = 1'b1;
      grant = 1'b1;
    end else if (loReq != '0 && !inProgHigh && !inProgLow) begin // R03
      pick = firstOne(loReq); // R21
      grant = 1'b1;
    end
  end

  // A halted core is always between instructions
  assign instrOk = cpuHalt |
                   (coreStatus.lastCycle & // R04
                    ~coreStatus.isReti & ~coreStatus.isIrqRegAccess); // R05
  assign takeCall = pollStrobe & instrOk & grant & ~oscStop; // R02

  // The core pushes the return address and jumps; the status word is
  // its own business and is not touched here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      forcedCall <= '0;
    end else if (internalReset) begin
      forcedCall <= '0;
    end else begin
      forcedCall.valid <= takeCall; // R07
      forcedCall.vector <= takeCall ? vectorOf(pick) : 16'h0000; // R08
      forcedCall.ackOneHot <= takeCall ? pick : '0;
    end
  end

  // Only an interrupt return or a reset clears a marker; a plain return never
  // reaches this block, so its level stays blocked
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      inProgLow <= 1'b0;
      inProgHigh <= 1'b0;
    end else if (internalReset) begin
      inProgLow <= 1'b0; // R24
      inProgHigh <= 1'b0;
    end else if (takeCall) begin
      if (pickHigh) begin
        inProgHigh <= 1'b1;
      end else begin
        inProgLow <= 1'b1;
      end
    end else if (retiStrobe) begin // R09 R10
      if (inProgHigh) begin
        inProgHigh <= 1'b0;
      end else begin
        inProgLow <= 1'b0;
      end
    end
  end

  // ***************************************************
  // Power modes
  // ***************************************************

  always_comb begin
    next_power = powerControl;
    if (takeCall) begin
      next_power[`PC_IDLE] = 1'b0; // R14
    end
    if (busWrite && busSel == SEL_POWER) begin
      next_power = pwdata[7:0]; // R19
      // Power-down is left only through reset
      next_power[`PC_PD] = pwdata[`PC_PD] | powerControl[`PC_PD]; // R17
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      powerControl <= `RST_POWER;
      cpuHalt <= 1'b0;
      oscStop <= 1'b0;
      unitDisable <= 1'b0;
    end else if (internalReset) begin
      powerControl <= `RST_POWER; // R24
      cpuHalt <= 1'b0;
      oscStop <= 1'b0;
      unitDisable <= 1'b0;
    end else begin
      powerControl <= next_power;
      cpuHalt <= next_power[`PC_IDLE] | next_power[`PC_PD]; // R13
      oscStop <= next_power[`PC_PD]; // R17
      unitDisable <= next_power[`PC_PD]; // R18
    end
  end

  // Detection must survive power-down, so it never follows the mode bits
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lowVoltDetectOn <= 1'b0;
    end else begin
      lowVoltDetectOn <= 1'b1; // R18
    end
  end

  // Hold the core for a fixed count of machine cycles after internal reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      restartCount <= 2'd0;
      restartHold <= 1'b0;
    end else if (internalReset) begin
      restartCount <= `RESTART_CYCLES; // R16
      restartHold <= 1'b1;
    end else if (sampleStrobe && restartCount != 2'd0) begin
      restartCount <= restartCount - 2'd1;
      restartHold <= (restartCount != 2'd1);
    end
  end

  assign serial1DoubleRate = powerControl[`PC_DBL1];
  assign serial2DoubleRate = powerControl[`PC_DBL2];
  assign lowVoltResetDisable = powerControl[`PC_LVR];
  assign converterIrqEnable = powerControl[`PC_ADC];
  assign serial2RxClockSel = powerControl[`PC_RXCLK];
  assign serial2TxClockSel = powerControl[`PC_TXCLK];

endmodule : irq_dispatch_power_modes

// ===== include/irq_dispatch_defs.svh
// Constants for the interrupt dispatch and power mode block
`ifndef IRQ_DISPATCH_DEFS_SVH
`define IRQ_DISPATCH_DEFS_SVH

`define NUM_SRC 8
`define ADDR_W 12

// Register indices; byte address is four times the index
`define IDX_POWER 8'h87
`define IDX_PRIO_MAIN 8'hb8
`define IDX_PRIO_EXTRA 8'hb7
`define IDX_EN_MAIN 8'ha8
`define IDX_EN_EXTRA 8'ha7
`define IDX_STATUS 8'hc0

`define RST_POWER 8'h00
`define RST_PRIO 8'h00
`define RST_EN 8'h00

// Power control fields
`define PC_IDLE 0
`define PC_PD 1
`define PC_TXCLK 2
`define PC_RXCLK 3
`define PC_ADC 4
`define PC_LVR 5
`define PC_DBL2 6
`define PC_DBL1 7

// Priority and enable fields
`define B_EXT0 0
`define B_T0 1
`define B_EXT1 2
`define B_T1 3
`define B_SER1 4
`define B_T2 5
`define B_GLOBAL 7
`define B_TWOWIRE 1
`define B_SER2 4

`define MASK_PRIO_MAIN 8'h3f
`define MASK_EXTRA 8'h12
`define MASK_EN_MAIN 8'hbf

// Status fields
`define ST_PROG_LO 0
`define ST_PROG_HI 1
`define ST_OSC_STOP 2

// Service vectors
`define VEC_EXT0 16'h0003
`define VEC_T0 16'h000b
`define VEC_EXT1 16'h0013
`define VEC_T1 16'h001b
`define VEC_SER1 16'h0023
`define VEC_T2 16'h002b
`define VEC_TWOWIRE 16'h0043
`define VEC_SER2 16'h004b

`define RESTART_CYCLES 2'd3

`endif

// ===== include/irq_dispatch_pkg.sv
// Types shared by the interrupt dispatch block and its bench
package irq_dispatch_pkg;

  // Source positions follow the fixed polling order, 0 polled first
  typedef enum logic [2:0] {
    SRC_EXT0 = 3'b000,
    SRC_SER2 = 3'b001,
    SRC_T0 = 3'b010,
    SRC_TWOWIRE = 3'b011,
    SRC_EXT1 = 3'b100,
    SRC_T1 = 3'b101,
    SRC_SER1 = 3'b110,
    SRC_T2 = 3'b111
  } src_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_POWER = 3'b001,
    SEL_PRIO_MAIN = 3'b010,
    SEL_PRIO_EXTRA = 3'b011,
    SEL_EN_MAIN = 3'b100,
    SEL_EN_EXTRA = 3'b101,
    SEL_STATUS = 3'b110
  } reg_sel_t;

  typedef struct packed {
    logic lastCycle;
    logic isReti;
    logic isIrqRegAccess;
  } core_status_t;

  typedef struct packed {
    logic valid;
    logic [15:0] vector;
    logic [7:0] ackOneHot;
  } call_t;

endpackage : irq_dispatch_pkg

// ===== verif/core_seq_model.sv
// Core sequencer model: machine-cycle sample and poll strobes
`timescale 1ns/1ns

module core_seq_model (
  input wire logic clk_sys,
  input wire logic resetn,
  output logic sampleStrobe,
  output logic pollStrobe
);
  // ******************************
  // Strobes
  // ******************************
  // Two clocks per machine cycle keeps the run short; poll follows sample
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sampleStrobe <= 1'b0;
      pollStrobe <= 1'b0;
    end else begin
      sampleStrobe <= !sampleStrobe;
      pollStrobe <= sampleStrobe;
    end
  end
endmodule : core_seq_model

// ===== verif/irq_dispatch_power_modes_chk.sv
// Property checker for the interrupt dispatch block
`timescale 1ns/1ns
`include "irq_dispatch_defs.svh"

module irq_dispatch_power_modes_chk
  import irq_dispatch_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pollStrobe,
  input wire core_status_t coreStatus,
  input wire logic internalReset,
  input wire call_t forcedCall,
  input wire logic cpuHalt,
  input wire logic oscStop,
  input wire logic unitDisable,
  input wire logic lowVoltDetectOn,
  input wire logic restartHold
);
  // ******************************
  // Properties
  // ******************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  function automatic logic [15:0] vecOf(input logic [7:0] h);
    case (h)
      8'h01: vecOf = `VEC_EXT0;
      8'h02: vecOf = `VEC_SER2;
      8'h04: vecOf = `VEC_T0;
      8'h08: vecOf = `VEC_TWOWIRE;
      8'h10: vecOf = `VEC_EXT1;
      8'h20: vecOf = `VEC_T1;
      8'h40: vecOf = `VEC_SER1;
      default: vecOf = `VEC_T2;
    endcase
  endfunction : vecOf

  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  call_after_poll_a: assert property (forcedCall.valid |-> $past(pollStrobe))
    else $error("call without poll");
  call_pulse_a: assert property (forcedCall.valid |=> !forcedCall.valid)
    else $error("call longer than one cycle");
  vector_map_a: assert property (forcedCall.valid |-> $onehot(forcedCall.ackOneHot)
    && forcedCall.vector == vecOf(forcedCall.ackOneHot)) else $error("wrong vector");
  not_last_a: assert property (pollStrobe && !cpuHalt && !coreStatus.lastCycle
    |=> !forcedCall.valid) else $error("call mid instruction");
  return_from_interrupt_block_a: assert property (pollStrobe && !cpuHalt &&
    (coreStatus.isReti || coreStatus.isIrqRegAccess) |=> !forcedCall.valid)
    else $error("call during return or register access");
  wake_a: assert property (forcedCall.valid |-> !cpuHalt)
    else $error("halt kept during call");
  pd_hold_a: assert property (oscStop && !internalReset |=> oscStop)
    else $error("power-down left without reset");
  pd_no_call_a: assert property (oscStop |=> !forcedCall.valid)
    else $error("call in power-down");
  pd_units_a: assert property (oscStop |-> unitDisable && cpuHalt && lowVoltDetectOn)
    else $error("power-down unit state wrong");
  restart_a: assert property (internalReset |=> restartHold [*3])
    else $error("restart hold too short");
  int_reset_a: assert property (internalReset |=> !cpuHalt && !oscStop)
    else $error("internal reset kept a power mode");
endmodule : irq_dispatch_power_modes_chk

bind irq_dispatch_power_modes irq_dispatch_power_modes_chk u_chk (.clk_sys(clk_sys),
  .resetn(resetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .pollStrobe(pollStrobe), .coreStatus(coreStatus), .internalReset(internalReset),
  .forcedCall(forcedCall), .cpuHalt(cpuHalt), .oscStop(oscStop), .unitDisable(unitDisable),
  .lowVoltDetectOn(lowVoltDetectOn), .restartHold(restartHold));

// ===== verif/test_irq_dispatch_power_modes.sv
// Self-checking bench for the interrupt dispatch and power mode block
`timescale 1ns/1ns
`include "irq_dispatch_defs.svh"

module test_irq_dispatch_power_modes
  import irq_dispatch_pkg::*;
;
  // ******************************
  // Bench
  // ******************************
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, sampleStrobe, pollStrobe, cpuHalt, oscStop, unitDisable;
  logic lowVoltDetectOn, restartHold, s1Dbl, s2Dbl, lvrDis, convEn, rxSel, txSel;
  logic retiStrobe = 1'b0;
  logic adcDone = 1'b0;
  logic internalReset = 1'b0;
  logic [`NUM_SRC-1:0] irqFlags = '0;
  core_status_t coreStatus = 3'b100;
  call_t forcedCall;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [15:0] vecTab [8] = '{`VEC_EXT0, `VEC_SER2, `VEC_T0, `VEC_TWOWIRE, `VEC_EXT1,
    `VEC_T1, `VEC_SER1, `VEC_T2};
  logic [7:0] regIdx [3] = '{`IDX_POWER, `IDX_PRIO_MAIN, `IDX_PRIO_EXTRA};
  logic [7:0] regRd [3] = '{8'hfc, `MASK_PRIO_MAIN, `MASK_EXTRA};
  logic [2:0] blockSt [3] = '{3'b000, 3'b110, 3'b101};

  always #20 clk_sys = ~clk_sys;

  irq_dispatch_power_modes u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sampleStrobe(sampleStrobe),
    .pollStrobe(pollStrobe), .coreStatus(coreStatus), .retiStrobe(retiStrobe),
    .irqFlags(irqFlags), .adcDone(adcDone), .internalReset(internalReset),
    .forcedCall(forcedCall), .cpuHalt(cpuHalt), .oscStop(oscStop),
    .unitDisable(unitDisable), .lowVoltDetectOn(lowVoltDetectOn),
    .restartHold(restartHold), .serial1DoubleRate(s1Dbl), .serial2DoubleRate(s2Dbl),
    .lowVoltResetDisable(lvrDis), .converterIrqEnable(convEn),
    .serial2RxClockSel(rxSel), .serial2TxClockSel(txSel));

  core_seq_model u_seq (.clk_sys(clk_sys), .resetn(resetn), .sampleStrobe(sampleStrobe),
    .pollStrobe(pollStrobe));

  task automatic end_of_test;
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // A hang counts as a mismatch
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    chk("slave error", pslverr, idx == 8'h10);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // First call seen in a 12-cycle window; zero means none expected
  task automatic expectCall(input string nm, input logic [15:0] vec);
    logic [15:0] got;
    got = 16'h0;
    repeat (12) begin
      @(posedge clk_sys);
      if (forcedCall.valid === 1'b1 && got === 16'h0) got = forcedCall.vector;
    end
    chk(nm, got, vec);
  endtask : expectCall

  task automatic return_from_interrupt;
    @(posedge clk_sys);
    retiStrobe <= 1'b1;
    @(posedge clk_sys);
    retiStrobe <= 1'b0;
  endtask : return_from_interrupt

  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(0, regIdx[i], 8'h0);
      chk("reset value", rd, 0);
      apb(1, regIdx[i], i == 0 ? 8'hfc : 8'hff);
      apb(0, regIdx[i], 8'h0);
      chk("field mask", rd, regRd[i]);
      if (i == 0) chk("power fields", {s1Dbl, s2Dbl, lvrDis, convEn, rxSel, txSel}, 6'h3f);
      apb(1, regIdx[i], 8'h0);
    end
    apb(0, 8'h10, 8'h0);
    chk("unmapped read", rd, 0);
    apb(1, `IDX_EN_MAIN, `MASK_EN_MAIN);
    apb(1, `IDX_EN_EXTRA, `MASK_EXTRA);
    for (int i = 0; i < 8; i++) begin
      irqFlags <= 8'h01 << i;
      expectCall("vector", vecTab[i]);
      irqFlags <= '0;
      return_from_interrupt();
    end
    irqFlags <= 8'hff;
    expectCall("poll order", `VEC_EXT0);
    expectCall("low blocks low", 0);
    apb(1, `IDX_PRIO_MAIN, 8'h20);
    expectCall("high preempts low", `VEC_T2);
    apb(1, `IDX_PRIO_EXTRA, 8'h10);
    expectCall("high not preempted", 0);
    apb(0, `IDX_STATUS, 8'h0);
    chk("markers set", rd, 3);
    irqFlags <= '0;
    return_from_interrupt();
    return_from_interrupt();
    apb(0, `IDX_STATUS, 8'h0);
    chk("markers cleared", rd, 0);
    apb(1, `IDX_PRIO_MAIN, 8'h0);
    apb(1, `IDX_PRIO_EXTRA, 8'h0);
    apb(1, `IDX_EN_MAIN, 8'h3f);
    irqFlags <= 8'h01;
    expectCall("global off", 0);
    irqFlags <= '0;
    apb(1, `IDX_EN_MAIN, `MASK_EN_MAIN);
    for (int i = 0; i < 3; i++) begin
      coreStatus <= blockSt[i];
      irqFlags <= 8'h01;
      expectCall("blocked", 0);
      // Let a machine cycle sample the dropped flag before the block lifts
      irqFlags <= '0;
      repeat (2) @(posedge clk_sys);
      coreStatus <= 3'b100;
      expectCall("denied forgotten", 0);
    end
    apb(1, `IDX_POWER, 8'h01);
    @(posedge clk_sys);
    chk("idle halts", cpuHalt, 1);
    coreStatus <= 3'b000;
    irqFlags <= 8'h01;
    expectCall("idle wake", `VEC_EXT0);
    chk("idle cleared", cpuHalt, 0);
    irqFlags <= '0;
    coreStatus <= 3'b100;
    return_from_interrupt();
    apb(1, `IDX_POWER, 8'h10);
    adcDone <= 1'b1;
    expectCall("converter request", `VEC_EXT1);
    adcDone <= 1'b0;
    return_from_interrupt();
    @(posedge clk_sys) internalReset <= 1'b1;
    @(posedge clk_sys) internalReset <= 1'b0;
    @(negedge clk_sys);
    chk("restart hold", restartHold, 1);
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("restart done", restartHold, 0);
    apb(1, `IDX_POWER, 8'h02);
    apb(1, `IDX_POWER, 8'h00);
    @(negedge clk_sys);
    chk("power-down", {oscStop, unitDisable, cpuHalt, lowVoltDetectOn}, 4'hf);
    apb(0, `IDX_STATUS, 8'h0);
    chk("status osc", rd, 4);
    @(posedge clk_sys) resetn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    chk("reset wakes", {oscStop, cpuHalt}, 0);
    end_of_test();
  end
endmodule : test_irq_dispatch_power_modes
